// ### bench/gaws_checker.sv
// Assertion checker for the gate alert and warning supervisor
`timescale 1ns/1ps
`default_nettype none
module gaws_checker #(
  parameter int SEC_CYCLES = 20,
  parameter int DIAG_SEC = 60
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] warn_before_move_setting,
  input wire logic beam_alignment_aid,
  input wire logic clock_load,
  input wire logic [3:0] display_contrast_level,
  input wire logic contrast_write,
  input wire logic detailed_logging_write,
  input wire logic forced_open_alert_enable,
  input wire logic drift_closed_alert_enable,
  input wire logic fault_detected,
  input wire logic close_limit_pin,
  input wire logic reset_button_pin,
  input wire logic motor_open,
  input wire logic motor_close,
  input wire logic buzzer,
  input wire logic [3:0] alert_code,
  input wire logic [3:0] contrast_out,
  input wire logic clock_setting_mode,
  input wire logic detailed_logging_active,
  input wire logic alignment_mode
);
  int run_cnt;
  int diag_cnt;
  logic moving;
  logic quiet_in;
  // Nothing but the warning itself may sound the buzzer
  assign moving = motor_open || motor_close;
  assign quiet_in = !forced_open_alert_enable && !drift_closed_alert_enable && !fault_detected &&
    !beam_alignment_aid && !alignment_mode && alert_code == 4'h0;
  // Cycles of unbroken motor run and of detailed logging
  always_ff @(posedge ref_clk) begin
    run_cnt <= (!rstn || !moving) ? 0 : run_cnt + 1;
    diag_cnt <= (!rstn || !detailed_logging_active || detailed_logging_write) ? 0 : diag_cnt + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_contrast_load;
    contrast_write && display_contrast_level <= 4'h9 |=> contrast_out == $past(display_contrast_level);
  endproperty
  a_contrast_load: assert property (p_contrast_load) else $error("contrast not loaded");
  property p_contrast_keep;
    contrast_write && display_contrast_level > 4'h9 |=> $stable(contrast_out);
  endproperty
  a_contrast_keep: assert property (p_contrast_keep) else $error("bad contrast taken");
  property p_clk_load;
    clock_load |=> !clock_setting_mode;
  endproperty
  a_clk_load: assert property (p_clk_load) else $error("clock item not cleared");
  property p_warn_full;
    warn_before_move_setting == 2'h1 && moving && run_cnt > 0 |-> buzzer;
  endproperty
  a_warn_full: assert property (p_warn_full) else $error("buzzer off in travel");
  property p_warn_part;
    warn_before_move_setting == 2'h2 && quiet_in && run_cnt > 2 * SEC_CYCLES + 4 |-> !buzzer;
  endproperty
  a_warn_part: assert property (p_warn_part) else $error("buzzer past 2 s");
  property p_motor_after_warn;
    $rose(moving) && warn_before_move_setting != 2'h0 |-> $past(buzzer);
  endproperty
  a_motor_after_warn: assert property (p_motor_after_warn) else $error("motor before warning");
  property p_quiet;
    (quiet_in && warn_before_move_setting == 2'h0) [*8] |-> !buzzer;
  endproperty
  a_quiet: assert property (p_quiet) else $error("buzzer with warning off");
  property p_align_exit;
    (close_limit_pin || reset_button_pin) [*5] |-> !alignment_mode;
  endproperty
  a_align_exit: assert property (p_align_exit) else $error("alignment mode kept");
  property p_recover_max;
    alert_code != 4'h0 && moving |-> run_cnt <= 4 * SEC_CYCLES + 2;
  endproperty
  a_recover_max: assert property (p_recover_max) else $error("recovery run too long");
  property p_diag_expire;
    detailed_logging_active |-> diag_cnt <= (DIAG_SEC + 1) * SEC_CYCLES + 4;
  endproperty
  a_diag_expire: assert property (p_diag_expire) else $error("detailed logging kept");
  c_forced: cover property (motor_close && alert_code == 4'h1);
  c_chirp: cover property (alignment_mode && $rose(buzzer));
  c_diag_end: cover property ($fell(detailed_logging_active));
endmodule : gaws_checker
bind gaws_supervisor gaws_checker #(.SEC_CYCLES(SEC_CYCLES), .DIAG_SEC(DIAG_SEC)) u_chk (.*);
`default_nettype wire

// ### bench/gaws_gate_model.sv
// Behavioural gate: motor travel, limit switches and beam
`timescale 1ns/1ps
`default_nettype none
module gaws_gate_model #(
  parameter int TRAVEL = 100
) (
  input wire logic ref_clk,
  input wire logic motor_open,
  input wire logic motor_close,
  input wire logic stall,
  input wire logic shove_open,
  input wire logic shove_close,
  input wire logic beam_block,
  output logic open_limit_pin,
  output logic close_limit_pin,
  output logic beam_aligned_pin
);
  int pos = 0;
  // A shove beats the motor; a stalled gate ignores the motor
  always @(posedge ref_clk) begin
    if (shove_open && pos < TRAVEL) pos <= pos + 1;
    else if (shove_close && pos > 0) pos <= pos - 1;
    else if (!stall && motor_open && pos < TRAVEL) pos <= pos + 1;
    else if (!stall && motor_close && pos > 0) pos <= pos - 1;
  end
  assign open_limit_pin = (pos == TRAVEL);
  assign close_limit_pin = (pos == 0);
  assign beam_aligned_pin = !beam_block;
endmodule : gaws_gate_model
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the gate alert and warning supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SC = 20;
  logic ref_clk = 0, rstn = 0, beam_alignment_aid = 0, clock_set_item = 0, clock_load = 0;
  logic contrast_write = 0, detailed_logging_enable = 0, detailed_logging_write = 0, menu_changed = 0;
  logic forced_open_alert_enable = 0, drift_closed_alert_enable = 0, event_log_view_enable = 0;
  logic fault_detected = 0, move_open_req = 0, move_close_req = 0, reset_button_pin = 0;
  logic stall = 0, shove_open = 0, shove_close = 0, beam_block = 0;
  logic [1:0] warn_before_move_setting = 2'h0;
  logic [3:0] display_contrast_level = 4'h0;
  logic [8:0] log_view_index = 9'h000;
  logic [31:0] clock_load_value = 32'h0000_0100;
  logic open_limit_pin, close_limit_pin, beam_aligned_pin, motor_open, motor_close, buzzer;
  logic clock_setting_mode, detailed_logging_active, alignment_mode, log_view_valid, log_wrapped;
  logic [3:0] alert_code, contrast_out, log_view_code;
  logic [31:0] clock_seconds, log_view_stamp;
  int n_errors = 0;
  int n_compared = 0;
  // Short second so that alert timings fit the run
  gaws_supervisor #(.SEC_CYCLES(SC), .DIAG_SEC(60)) DUT (.*);
  gaws_gate_model #(.TRAVEL(100)) u_gate (.*);
  always #12.5 ref_clk = ~ref_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic check_cnt(input int n, input int lo, input int hi);
    n_compared++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h to %h", $time, n, lo, hi);
    end
  endtask : check_cnt
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // Bounded wait on motor state; counts buzzer cycles meanwhile
  task automatic wait_motor(input logic want, output int w, output int b);
    w = 0;
    b = 0;
    while ((motor_open | motor_close) !== want) begin
      tick(1);
      w++;
      b += (buzzer === 1);
      if (w > 3000) begin
        n_errors++;
        finish_test();
      end
    end
  endtask : wait_motor
  task automatic do_reset;
    @(posedge ref_clk);
    rstn <= 0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1;
    tick(4);
  endtask : do_reset
  task automatic view(input logic [8:0] i, input logic [3:0] code);
    @(posedge ref_clk);
    event_log_view_enable <= 1;
    log_view_index <= i;
    tick(4);
    check(log_view_valid, 1);
    check(log_view_code, code);
  endtask : view
  task automatic put_contrast(input logic [3:0] v, input logic [3:0] exp);
    @(posedge ref_clk);
    display_contrast_level <= v;
    contrast_write <= 1;
    @(posedge ref_clk);
    contrast_write <= 0;
    tick(2);
    check(contrast_out, exp);
  endtask : put_contrast
  task automatic t_log;
    @(posedge ref_clk);
    clock_set_item <= 1;
    @(posedge ref_clk);
    clock_set_item <= 0;
    tick(2);
    check(clock_setting_mode, 1);
    @(posedge ref_clk);
    clock_load <= 1;
    @(posedge ref_clk);
    clock_load <= 0;
    menu_changed <= 1;
    detailed_logging_enable <= 1;
    detailed_logging_write <= 1;
    @(posedge ref_clk);
    menu_changed <= 0;
    detailed_logging_write <= 0;
    tick(2);
    check(clock_setting_mode, 0);
    check(clock_seconds >= 32'h0000_0100 && clock_seconds < 32'h0000_0103, 1);
    check(detailed_logging_active, 1);
    view(9'h000, 4'h7);
    view(9'h001, 4'h6);
    check(log_view_stamp >= 32'h0000_0100 && log_view_stamp < 32'h0000_0103, 1);
    $display("done: log");
  endtask : t_log
  task automatic t_move(input logic [1:0] s, input logic up);
    int w, b;
    @(posedge ref_clk);
    warn_before_move_setting <= s;
    move_open_req <= up;
    move_close_req <= !up;
    @(posedge ref_clk);
    move_open_req <= 0;
    move_close_req <= 0;
    wait_motor(1, w, b);
    check_cnt(w, (s != 2'h0) ? 2 * SC : 0, (s != 2'h0) ? 3 * SC + 4 : 4);
    check(b > 0, s != 2'h0);
    tick(SC + SC / 2);
    check(buzzer, s != 2'h0);
    tick(SC);
    check(buzzer, s == 2'h1);
    wait_motor(0, w, b);
    check(up ? open_limit_pin : close_limit_pin, 1);
    $display("done: move");
  endtask : t_move
  task automatic t_alert(input logic dr, input logic st);
    int w, b, len;
    len = dr ? 10 : 30;
    @(posedge ref_clk);
    forced_open_alert_enable <= !dr;
    drift_closed_alert_enable <= dr;
    stall <= st;
    shove_open <= !dr;
    shove_close <= dr;
    repeat (3) @(posedge ref_clk);
    shove_open <= 0;
    shove_close <= 0;
    wait_motor(1, w, b);
    check_cnt(b, 2 * SC - 4, 3 * SC + 8);
    check({motor_open, motor_close}, {dr, !dr});
    if (!dr) check(alert_code, 4'h1);
    wait_motor(0, w, b);
    if (st) begin
      check_cnt(w, 4 * SC - 2, 4 * SC + 4);
      tick((len - 2) * SC);
      check(buzzer, 1);
      tick(3 * SC);
      check(buzzer, 0);
      check(alert_code, dr ? 4'h2 : 4'h1);
      do_reset();
    end else begin
      check(dr ? open_limit_pin : close_limit_pin, 1);
    end
    @(posedge ref_clk);
    forced_open_alert_enable <= 0;
    drift_closed_alert_enable <= 0;
    stall <= 0;
    $display("done: alert");
  endtask : t_alert
  task automatic chirps(output int n);
    logic last;
    n = 0;
    last = buzzer;
    repeat (20000) begin
      tick(1);
      n += (buzzer === 1 && last !== 1);
      last = buzzer;
    end
  endtask : chirps
  task automatic t_align;
    int n;
    @(posedge ref_clk);
    beam_block <= 1;
    beam_alignment_aid <= 1;
    chirps(n);
    check_cnt(n, 1, 1);
    check(alignment_mode, 1);
    @(posedge ref_clk);
    beam_block <= 0;
    chirps(n);
    check_cnt(n, 2, 2);
    @(posedge ref_clk);
    beam_block <= 1;
    chirps(n);
    check_cnt(n, 1, 1);
    @(posedge ref_clk);
    reset_button_pin <= 1;
    tick(5);
    check(alignment_mode, 0);
    @(posedge ref_clk);
    reset_button_pin <= 0;
    chirps(n);
    check_cnt(n, 1, 1);
    check(alignment_mode, 1);
    t_move(2'h0, 0);
    tick(4);
    check(alignment_mode, 0);
    @(posedge ref_clk);
    beam_alignment_aid <= 0;
    beam_block <= 0;
    $display("done: align");
  endtask : t_align
  // Pulse every other cycle, past the log depth
  task automatic t_wrap;
    check(log_wrapped, 0);
    for (int i = 0; i < 1100; i++) begin
      @(posedge ref_clk);
      menu_changed <= !menu_changed;
      if (i == 1000) check(log_wrapped, 0);
    end
    tick(3);
    check(log_wrapped, 1);
    view(9'h000, 4'h6);
    $display("done: wrap");
  endtask : t_wrap
  initial begin
    int i;
    do_reset();
    check(contrast_out, 4'h5);
    check({motor_open, motor_close, buzzer, alert_code}, 0);
    put_contrast(4'h0, 4'h0);
    put_contrast(4'h9, 4'h9);
    put_contrast(4'hA, 4'h9);
    t_log();
    t_move(2'h0, 1);
    t_move(2'h1, 0);
    t_move(2'h2, 1);
    view(9'h002, 4'h1);
    for (i = 0; i < 70 * SC && detailed_logging_active; i++) tick(1);
    check(detailed_logging_active, 0);
    @(posedge ref_clk);
    warn_before_move_setting <= 2'h0;
    fault_detected <= 1;
    tick(4);
    check(buzzer, 1);
    @(posedge ref_clk);
    fault_detected <= 0;
    t_align();
    t_alert(0, 0);
    t_alert(0, 1);
    t_move(2'h0, 1);
    t_alert(1, 0);
    t_alert(1, 1);
    t_wrap();
    finish_test();
  end
endmodule : tb
`default_nettype wire

// ### rtl/gaws_event_log.sv
// Circular event log with time stamps and wrap flag
`timescale 1ns/1ps
`default_nettype none
`include "gaws_regs.svh"
module gaws_event_log #(
  parameter int DEPTH = `GAWS_LOG_DEPTH,
  parameter int STAMP_W = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [3:0] wr_code,
  input wire logic [STAMP_W-1:0] wr_stamp,
  input wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic [3:0] rd_code,
  output logic [STAMP_W-1:0] rd_stamp,
  output logic [$clog2(DEPTH)-1:0] wr_ptr,
  output logic wrapped
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH <= 300 || (1 << AW) != DEPTH) $error("log depth must be a power of two above 300");
  end
  logic [STAMP_W+3:0] mem [DEPTH];
  wire last_slot = (wr_ptr == AW'(DEPTH - 1));
  // Storage, no reset needed for the array itself
  always_ff @(posedge ref_clk) begin
    if (wr_en) mem[wr_ptr] <= {wr_code, wr_stamp};
    {rd_code, rd_stamp} <= mem[rd_index];
  end
  // Pointer wraps onto the oldest entry
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      wrapped <= 1'b0;
    end else if (wr_en) begin
      wr_ptr <= wr_ptr + AW'(1);
      if (last_slot) wrapped <= 1'b1;
    end
  end
endmodule : gaws_event_log
`default_nettype wire

// ### rtl/gaws_pkg.sv
// Types for the gate alert and warning supervisor
package gaws_pkg;
  typedef enum logic [2:0] {
    GAWS_IDLE = 3'b000,
    GAWS_WARN = 3'b001,
    GAWS_MOVE = 3'b011,
    GAWS_ALARM = 3'b010,
    GAWS_DONE = 3'b110
  } gaws_state_t;
  typedef enum logic [1:0] {
    GAWS_DIR_NONE = 2'b00,
    GAWS_DIR_OPEN = 2'b01,
    GAWS_DIR_CLOSE = 2'b10
  } gaws_dir_t;
endpackage : gaws_pkg

// ### rtl/gaws_regs.svh
// Constants for the gate alert and warning supervisor
`ifndef GAWS_REGS_SVH
`define GAWS_REGS_SVH
// Timing in seconds, counted against the seconds tick
`define GAWS_CLK_HZ 40000000
`define GAWS_WARN_SEC 3
`define GAWS_PARTIAL_SEC 2
`define GAWS_RECOVER_SEC 4
`define GAWS_FORCED_BUZZ_SEC 30
`define GAWS_DRIFT_BUZZ_SEC 10
`define GAWS_DIAG_HOURS 24
`define GAWS_DIAG_SEC (`GAWS_DIAG_HOURS * 3600)
// Chirp shape in clock cycles
`define GAWS_CHIRP_CYC 16'h0FA0
`define GAWS_CHIRP_GAP 16'h0FA0
// Setting encodings
`define GAWS_WARN_OFF 2'h0
`define GAWS_WARN_FULL 2'h1
`define GAWS_WARN_PART 2'h2
`define GAWS_CONTRAST_MAX 4'h9
`define GAWS_CONTRAST_DEF 4'h5
// Alert codes on the display
`define GAWS_ALERT_NONE 4'h0
`define GAWS_ALERT_FORCED 4'h1
`define GAWS_ALERT_DRIFT 4'h2
// Log event codes
`define GAWS_EV_OPEN 4'h1
`define GAWS_EV_CLOSE 4'h2
`define GAWS_EV_FORCED 4'h3
`define GAWS_EV_DRIFT 4'h4
`define GAWS_EV_FAULT 4'h5
`define GAWS_EV_MENU 4'h6
`define GAWS_EV_CLOCKSET 4'h7
`define GAWS_LOG_DEPTH 512
`endif

// ### rtl/gaws_supervisor.sv
// Gate alert and warning supervisor top level
//==============================================================
// Summary of operation
// - Setting 0: no pre-move buzz, alerts still buzz
// - Setting 1: buzz 3 s, then whole travel
// - Setting 2: buzz 3 s, then 2 s travel
// - Alignment aid: one chirp when misaligned
// - Two chirps on alignment, one on loss
// - Close limit or reset ends alignment aid
// - Clock set item returns to 0 after set
// - Log events stamped with current time
// - Contrast 0 to 9, default 5
// - Detailed logging logs each open and close unless another event logs that cycle
// - Detailed logging self-clears after 24 hours
// - Faults logged unless an alert logs that cycle, menu changes unless an alert or fault does
// - Forced open: warn 3 s, then close
// - Close not done in 4 s: stop, buzz 30 s
// - Forced open shows alert code 1
// - Drift off open limit: warn, then open
// - Open not done in 4 s: buzz 10 s, code 2
// - Log view shows abbreviated entries
// - Log holds over 300, overwrites oldest
`timescale 1ns/1ps
`default_nettype none
`include "gaws_regs.svh"
module gaws_supervisor
  import gaws_pkg::*;
#(
  parameter int CLK_HZ = `GAWS_CLK_HZ,
  parameter int SEC_CYCLES = CLK_HZ,
  parameter int DIAG_SEC = `GAWS_DIAG_SEC,
  parameter int LOG_DEPTH = `GAWS_LOG_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] warn_before_move_setting,
  input wire logic beam_alignment_aid,
  input wire logic clock_set_item,
  input wire logic clock_load,
  input wire logic [31:0] clock_load_value,
  input wire logic [3:0] display_contrast_level,
  input wire logic contrast_write,
  input wire logic detailed_logging_enable,
  input wire logic detailed_logging_write,
  input wire logic forced_open_alert_enable,
  input wire logic drift_closed_alert_enable,
  input wire logic event_log_view_enable,
  input wire logic [$clog2(LOG_DEPTH)-1:0] log_view_index,
  input wire logic menu_changed,
  input wire logic fault_detected,
  input wire logic move_open_req,
  input wire logic move_close_req,
  input wire logic open_limit_pin,
  input wire logic close_limit_pin,
  input wire logic beam_aligned_pin,
  input wire logic reset_button_pin,
  output logic motor_open,
  output logic motor_close,
  output logic buzzer,
  output logic [3:0] alert_code,
  output logic [3:0] contrast_out,
  output logic clock_setting_mode,
  output logic detailed_logging_active,
  output logic alignment_mode,
  output logic [31:0] clock_seconds,
  output logic log_view_valid,
  output logic [3:0] log_view_code,
  output logic [31:0] log_view_stamp,
  output logic log_wrapped
);
  localparam int WARN_S = `GAWS_WARN_SEC;
  localparam int PART_S = `GAWS_PARTIAL_SEC;
  localparam int REC_S = `GAWS_RECOVER_SEC;
  localparam int AW = $clog2(LOG_DEPTH);
  initial begin
    if (SEC_CYCLES < 2) $error("SEC_CYCLES too small");
    if (DIAG_SEC < 1) $error("DIAG_SEC too small");
  end

  //==============================================================
  // Pin synchronisers
  logic [3:0] sync1;
  logic [3:0] sync2;
  always_ff @(posedge ref_clk) begin
    sync1 <= {open_limit_pin, close_limit_pin, beam_aligned_pin, reset_button_pin};
    sync2 <= sync1;
  end
  wire open_lim = sync2[3];
  wire close_lim = sync2[2];
  wire aligned = sync2[1];
  wire reset_btn = sync2[0];
  logic open_lim_d;
  logic close_lim_d;
  logic aligned_d;
  always_ff @(posedge ref_clk) begin
    open_lim_d <= open_lim;
    close_lim_d <= close_lim;
    aligned_d <= aligned;
  end
  wire close_lim_fall = close_lim_d && !close_lim;
  wire open_lim_fall = open_lim_d && !open_lim;
  wire close_lim_rise = !close_lim_d && close_lim;
  wire open_lim_rise = !open_lim_d && open_lim;

  //==============================================================
  // Seconds tick and wall clock
  logic [31:0] div_cnt;
  wire sec_tick = (div_cnt == 32'(SEC_CYCLES - 1));
  always_ff @(posedge ref_clk) begin
    if (!rstn) div_cnt <= '0;
    else div_cnt <= sec_tick ? '0 : div_cnt + 32'h0000_0001;
  end
  // Seconds since epoch; loading leaves clock-set mode
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      clock_seconds <= '0;
      clock_setting_mode <= 1'b0;
    end else begin
      if (clock_load) clock_seconds <= clock_load_value;
      else if (sec_tick) clock_seconds <= clock_seconds + 32'h0000_0001;
      if (clock_load) clock_setting_mode <= 1'b0;
      else if (clock_set_item) clock_setting_mode <= 1'b1;
    end
  end

  //==============================================================
  // Contrast setting, range checked
  always_ff @(posedge ref_clk) begin
    if (!rstn) contrast_out <= `GAWS_CONTRAST_DEF;
    else if (contrast_write && display_contrast_level <= `GAWS_CONTRAST_MAX) contrast_out <= display_contrast_level;
  end

  // Detailed logging with 24 hour self clear
  logic [31:0] diag_cnt;
  wire diag_expire = detailed_logging_active && sec_tick && diag_cnt == 32'(DIAG_SEC - 1);
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      detailed_logging_active <= 1'b0;
      diag_cnt <= '0;
    end else if (detailed_logging_write) begin
      detailed_logging_active <= detailed_logging_enable;
      diag_cnt <= '0;
    end else if (diag_expire) begin
      detailed_logging_active <= 1'b0;
    end else if (detailed_logging_active && sec_tick) begin
      diag_cnt <= diag_cnt + 32'h0000_0001;
    end
  end

  //==============================================================
  // Motion sequencer: commands and alert recoveries
  gaws_state_t state;
  gaws_state_t next_state;
  gaws_dir_t dir;
  logic recovery;
  logic [5:0] sec_cnt;
  logic [5:0] alarm_len;
  wire forced_trig = forced_open_alert_enable && close_lim_fall && dir == GAWS_DIR_NONE;
  wire drift_trig = drift_closed_alert_enable && open_lim_fall && dir == GAWS_DIR_NONE;
  wire start_cmd = move_open_req || move_close_req;
  wire warn_needed = (warn_before_move_setting != `GAWS_WARN_OFF) || recovery;
  wire arrived = (dir == GAWS_DIR_OPEN) ? open_lim : close_lim;
  wire rec_timeout = recovery && sec_tick && sec_cnt == 6'(REC_S - 1);
  always_comb begin
    next_state = state;
    case (state)
      GAWS_IDLE: if (forced_trig || drift_trig || start_cmd) next_state = GAWS_WARN;
      GAWS_WARN: if (!warn_needed || (sec_tick && sec_cnt == 6'(WARN_S - 1))) next_state = GAWS_MOVE;
      GAWS_MOVE: begin
        if (arrived) next_state = GAWS_DONE;
        else if (rec_timeout) next_state = GAWS_ALARM;
      end
      GAWS_ALARM: if (sec_tick && sec_cnt == alarm_len - 6'h01) next_state = GAWS_DONE;
      GAWS_DONE: next_state = GAWS_IDLE;
      default: next_state = GAWS_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state <= GAWS_IDLE;
      sec_cnt <= '0;
    end else begin
      state <= next_state;
      if (next_state != state) sec_cnt <= '0;
      else if (sec_tick && sec_cnt != 6'h3F) sec_cnt <= sec_cnt + 6'h01;
    end
  end
  // Direction, alert code and alarm length latch at the trigger
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      dir <= GAWS_DIR_NONE;
      recovery <= 1'b0;
      alert_code <= `GAWS_ALERT_NONE;
      alarm_len <= '0;
    end else if (state == GAWS_IDLE) begin
      if (forced_trig) begin
        dir <= GAWS_DIR_CLOSE;
        recovery <= 1'b1;
        alert_code <= `GAWS_ALERT_FORCED;
        alarm_len <= 6'(`GAWS_FORCED_BUZZ_SEC);
      end else if (drift_trig) begin
        dir <= GAWS_DIR_OPEN;
        recovery <= 1'b1;
        alert_code <= `GAWS_ALERT_DRIFT;
        alarm_len <= 6'(`GAWS_DRIFT_BUZZ_SEC);
      end else if (move_open_req) begin
        dir <= GAWS_DIR_OPEN;
        recovery <= 1'b0;
      end else if (move_close_req) begin
        dir <= GAWS_DIR_CLOSE;
        recovery <= 1'b0;
      end
    end else if (state == GAWS_DONE) begin
      dir <= GAWS_DIR_NONE;
      recovery <= 1'b0;
      if (close_lim && alert_code == `GAWS_ALERT_FORCED) alert_code <= `GAWS_ALERT_NONE;
      if (open_lim && alert_code == `GAWS_ALERT_DRIFT) alert_code <= `GAWS_ALERT_NONE;
    end
  end
  // Motor only runs in the move state
  wire moving = (state == GAWS_MOVE);
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      motor_open <= 1'b0;
      motor_close <= 1'b0;
    end else begin
      motor_open <= (next_state == GAWS_MOVE) && dir == GAWS_DIR_OPEN;
      motor_close <= (next_state == GAWS_MOVE) && dir == GAWS_DIR_CLOSE;
    end
  end

  //==============================================================
  // Alignment aid and chirp generator
  logic [1:0] chirps_left;
  logic [15:0] chirp_cnt;
  logic chirp_on;
  wire align_exit = close_lim_rise || reset_btn || !beam_alignment_aid;
  wire align_enter = beam_alignment_aid && !alignment_mode && !close_lim && !reset_btn;
  wire gained = alignment_mode && aligned && !aligned_d;
  wire lost = alignment_mode && !aligned && aligned_d;
  wire chirp_step = (chirp_cnt == `GAWS_CHIRP_CYC + `GAWS_CHIRP_GAP - 16'h0001);
  always_ff @(posedge ref_clk) begin
    if (!rstn) alignment_mode <= 1'b0;
    else if (align_exit) alignment_mode <= 1'b0;
    else if (align_enter) alignment_mode <= 1'b1;
  end
  // New events restart the chirp train
  always_ff @(posedge ref_clk) begin
    if (!rstn || align_exit) begin
      chirps_left <= '0;
      chirp_cnt <= '0;
    end else if (align_enter && !aligned) begin
      chirps_left <= 2'h1;
      chirp_cnt <= '0;
    end else if (gained) begin
      chirps_left <= 2'h2;
      chirp_cnt <= '0;
    end else if (lost) begin
      chirps_left <= 2'h1;
      chirp_cnt <= '0;
    end else if (chirps_left != 2'h0) begin
      chirp_cnt <= chirp_step ? '0 : chirp_cnt + 16'h0001;
      if (chirp_step) chirps_left <= chirps_left - 2'h1;
    end
  end
  assign chirp_on = (chirps_left != 2'h0) && (chirp_cnt < `GAWS_CHIRP_CYC);

  //==============================================================
  // Buzzer: warning, travel, alarm, faults and chirps
  wire warn_buzz = (state == GAWS_WARN) && warn_needed;
  wire travel_full = warn_before_move_setting == `GAWS_WARN_FULL;
  wire travel_part = warn_before_move_setting == `GAWS_WARN_PART && sec_cnt < 6'(PART_S);
  wire travel_buzz = moving && (travel_full || travel_part || recovery);
  always_ff @(posedge ref_clk) begin
    if (!rstn) buzzer <= 1'b0;
    else buzzer <= warn_buzz || travel_buzz || state == GAWS_ALARM || fault_detected || chirp_on;
  end

  //==============================================================
  // Event logging
  logic fault_d;
  always_ff @(posedge ref_clk) begin
    if (!rstn) fault_d <= 1'b0;
    else fault_d <= fault_detected;
  end
  wire ev_travel = detailed_logging_active && (open_lim_rise || close_lim_rise);
  wire ev_fault = fault_detected && !fault_d;
  wire ev_alert = (state == GAWS_IDLE) && (forced_trig || drift_trig);
  wire log_we = ev_travel || ev_fault || menu_changed || ev_alert || clock_load;
  wire [3:0] log_code = ev_alert ? (forced_trig ? `GAWS_EV_FORCED : `GAWS_EV_DRIFT)
                      : ev_fault ? `GAWS_EV_FAULT
                      : menu_changed ? `GAWS_EV_MENU
                      : clock_load ? `GAWS_EV_CLOCKSET
                      : open_lim_rise ? `GAWS_EV_OPEN : `GAWS_EV_CLOSE;
  logic [3:0] rd_code;
  logic [31:0] rd_stamp;
  gaws_event_log #(
    .DEPTH(LOG_DEPTH),
    .STAMP_W(32)
  ) u_log (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr_en(log_we),
    .wr_code(log_code),
    .wr_stamp(clock_seconds),
    .rd_index(log_view_index),
    .rd_code(rd_code),
    .rd_stamp(rd_stamp),
    .wr_ptr(),
    .wrapped(log_wrapped)
  );
  // Abbreviated view only while the view item is on
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      log_view_valid <= 1'b0;
      log_view_code <= '0;
      log_view_stamp <= '0;
    end else begin
      log_view_valid <= event_log_view_enable;
      log_view_code <= event_log_view_enable ? rd_code : 4'h0;
      log_view_stamp <= event_log_view_enable ? rd_stamp : 32'h0000_0000;
    end
  end
endmodule : gaws_supervisor
`default_nettype wire
